// ---- acr_pkg.sv ----
// Package of register offsets, field positions, reset values and decode constants for the ADC configuration bank
// ==========================================================================
// Function
// - Decode rate code to samples per second
// - Ready flag sets on result, clears on read
// - Counter enable bit, reset zero
// - Integrity check select: none, inverted, CRC16
// - Burn-out sources bit, off after reset
// - Common excitation magnitude from three-bit code
// - First source route code, 111 reserved
// - Second source route code, 101 to 111 reserved
// - Reserved bits read zero, host writes zero
// - Result output mode: manual or automatic
// - Pin direction bits, inputs after reset
// - Pin 2 output source: level or ready
// - Level bits drive outputs, sample inputs
// - Registers at 02h-04h, all reset zero
// - Mode bit selects normal or double speed
package acr_pkg;

    // ==========================================================================
    // Register addresses
    localparam logic [7:0] ADDR_CHECK_EXC = 8'h02;  // result_check_and_excitation_config
    localparam logic [7:0] ADDR_ROUTE_OUT = 8'h03;  // excitation_routing_and_output_config
    localparam logic [7:0] ADDR_PIN_CTRL  = 8'h04;  // general_pin_control
    localparam logic [7:0] RESET_VALUE    = 8'h00;  // Every register resets to zero

    // ==========================================================================
    // Field positions, register 2
    localparam int POS_READY     = 7;
    localparam int POS_CNT_EN    = 6;
    localparam int POS_CHECK_LO  = 4;
    localparam int POS_BURNOUT   = 3;
    localparam int POS_LEVEL_LO  = 0;
    // Register 3
    localparam int POS_ROUTE1_LO = 5;
    localparam int POS_ROUTE2_LO = 2;
    localparam int POS_RSVD3     = 1;
    localparam int POS_AUTO      = 0;
    // Register 4
    localparam int POS_RSVD4     = 7;
    localparam int POS_DIR_LO    = 4;
    localparam int POS_PIN2_SEL  = 3;
    localparam int POS_PIN_LO    = 0;

    // Writable masks: read-only and reserved bits never take a write
    localparam logic [7:0] WMASK_CHECK_EXC = 8'h7f;
    localparam logic [7:0] WMASK_ROUTE_OUT = 8'hfd;
    localparam logic [7:0] WMASK_PIN_CTRL  = 8'h7f;

    // ==========================================================================
    // Decode constants
    localparam logic [2:0] RATE_RESERVED  = 3'h7;
    localparam logic [1:0] CHECK_RESERVED = 2'h3;
    localparam logic [2:0] ROUTE_RESERVED = 3'h7;
    localparam logic [2:0] ROUTE2_LAST    = 3'h4;   // Second source reaches inputs only

    // Integrity check modes
    typedef enum logic [1:0] {
        CHECK_NONE     = 2'h0,
        CHECK_INVERTED = 2'h1,
        CHECK_CRC16    = 2'h2,
        CHECK_BAD      = 2'h3
    } acr_check_type;

    // Sample rates, normal mode, samples per second
    localparam logic [15:0] RATE_SPS [0:6] = '{16'd20, 16'd45, 16'd90, 16'd175, 16'd330, 16'd600, 16'd1000};
    // Excitation magnitude, microamps
    localparam logic [15:0] LEVEL_UA [0:7] = '{16'd0, 16'd10, 16'd50, 16'd100, 16'd250, 16'd500, 16'd1000,
                                              16'd1500};
    // Modulator clock in kHz for each mode bit value
    localparam logic [15:0] MOD_KHZ_NORMAL = 16'd256;
    localparam logic [15:0] MOD_KHZ_DOUBLE = 16'd512;

endpackage : acr_pkg

// ---- acr_decode.sv ----
// Combinational decoder of rate, magnitude and modulator clock settings, registered for output
module acr_decode
    import acr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        double_speed,        // Mode bit
    input  wire logic [2:0]  sample_rate_code,    // Rate field
    input  wire logic [2:0]  excitation_current_level,
    output logic      [15:0] sample_rate_sps,     // 0 when code reserved
    output logic             rate_code_invalid,
    output logic      [15:0] excitation_ua,
    output logic      [15:0] modulator_khz
);
    logic [15:0] next_rate;   // Rate before register

    // ==========================================================================
    // Rate lookup; double speed doubles the normal column
    always_comb begin
        next_rate = 16'h0000;
        if (sample_rate_code != RATE_RESERVED) begin
            next_rate = RATE_SPS[sample_rate_code];
            if (double_speed) begin
                next_rate = {next_rate[14:0], 1'b0};
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sample_rate_sps   <= 16'h0000;
            rate_code_invalid <= 1'b0;
            excitation_ua     <= 16'h0000;
            modulator_khz     <= MOD_KHZ_NORMAL;
        end else begin
            sample_rate_sps   <= next_rate;
            // Flags a host breaking the reserved-code promise
            rate_code_invalid <= (sample_rate_code == RATE_RESERVED);
            excitation_ua     <= LEVEL_UA[excitation_current_level];
            modulator_khz     <= double_speed ? MOD_KHZ_DOUBLE : MOD_KHZ_NORMAL;
        end
    end

endmodule : acr_decode

// ---- acr_bank.sv ----
// Top: configuration registers 2 to 4, ready flag, pin logic and setting decode
module acr_bank
    import acr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Register port from the command interpreter
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_write,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    // Settings held outside this bank
    input  wire logic        double_speed,
    input  wire logic [2:0]  sample_rate_code,
    // Conversion events
    input  wire logic        result_done,          // Pulse: new result available
    input  wire logic        result_read,          // Pulse: conversion data read
    // Pins
    input  wire logic [2:0]  pin_in,
    output logic      [2:0]  pin_out,
    output logic      [2:0]  pin_oe,
    // Configuration outputs
    output logic             result_ready_flag,
    output logic             conversion_counter_enable,
    output acr_check_type    integrity_check,
    output logic             burnout_source_enable,
    output logic      [2:0]  excitation_current_level,
    output logic      [2:0]  first_source_route,
    output logic      [2:0]  second_source_route,
    output logic             auto_output_mode,
    output logic             route_code_invalid,
    output logic      [15:0] sample_rate_sps,
    output logic             rate_code_invalid,
    output logic      [15:0] excitation_ua,
    output logic      [15:0] modulator_khz
);
    import acr_pkg::*;

    // ==========================================================================
    // Storage
    logic [6:0] cfg2;          // Bits 6:0 of register 2
    logic [7:0] cfg3;          // Register 3, bit 1 held zero
    logic [6:0] cfg4_ctrl;     // Direction, select, levels for outputs
    logic [2:0] pin_sampled;   // Sampled input levels
    logic [2:0] pin_dir;       // Direction bits
    logic [2:0] pin_level;     // Level bits as read back
    logic       next_pin2;     // Pin 2 drive before register
    logic       route1_bad;    // First route holds the reserved code
    logic       route2_bad;    // Second route points past the last input
    logic       check_bad;     // Integrity check holds the reserved code

    assign pin_dir = cfg4_ctrl[POS_DIR_LO +: 3];

    // ==========================================================================
    // Register 2 writable fields
    // A write lands on the edge where reg_write is high; the fields reach
    // their outputs one edge later through the registered field block,
    // so a host sees a new setting one edge after its write lands
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg2 <= RESET_VALUE[6:0];
        end else if (reg_write && reg_addr == ADDR_CHECK_EXC) begin
            // Bit 7 is outside the mask so a write never touches the flag
            cfg2 <= reg_wdata[6:0] & WMASK_CHECK_EXC[6:0];
        end
    end

    // ==========================================================================
    // Ready flag
    // A new result in the read cycle wins so none is lost
    // The flag is kept apart from cfg2 so no register write reaches it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            result_ready_flag <= 1'b0;
        end else if (result_done) begin
            result_ready_flag <= 1'b1;
        end else if (result_read) begin
            result_ready_flag <= 1'b0;
        end
    end

    // ==========================================================================
    // Register 3
    // Reserved bit stays zero
    // Routes are stored as written, reserved codes included
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg3 <= RESET_VALUE;
        end else if (reg_write && reg_addr == ADDR_ROUTE_OUT) begin
            cfg3 <= reg_wdata & WMASK_ROUTE_OUT;
        end
    end

    // ==========================================================================
    // Register 4
    // Bit 7 reserved and never stored
    // Level bits are stored for every pin, so a pin turned to output
    // drives the level that was written while it was still an input
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg4_ctrl <= RESET_VALUE[6:0];
        end else if (reg_write && reg_addr == ADDR_PIN_CTRL) begin
            cfg4_ctrl <= reg_wdata[6:0] & WMASK_PIN_CTRL[6:0];
        end
    end

    // ==========================================================================
    // Pin sampling
    // Sample pin inputs each cycle
    // Inputs are taken as synchronous, so one stage suffices; an input
    // therefore reads back one edge after the pin itself moves
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_sampled <= 3'h0;
        end else begin
            pin_sampled <= pin_in;
        end
    end

    // ==========================================================================
    // Pin drive: one slice per pin
    // Pin 2 may carry the ready flag; it trails the flag by one edge
    // because every pin drive is registered like the other outputs
    always_comb begin
        next_pin2 = cfg4_ctrl[POS_PIN2_SEL] ? result_ready_flag : cfg4_ctrl[POS_PIN_LO + 2];
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            // Read back the stored level bit on outputs, the sampled level on inputs
            assign pin_level[gi] = pin_dir[gi] ? cfg4_ctrl[POS_PIN_LO + gi] : pin_sampled[gi];
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    pin_oe[gi]  <= 1'b0;
                    pin_out[gi] <= 1'b0;
                end else begin
                    pin_oe[gi]  <= pin_dir[gi];
                    if (gi == 2) begin
                        pin_out[gi] <= next_pin2;
                    end else begin
                        pin_out[gi] <= cfg4_ctrl[POS_PIN_LO + gi];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================================
    // Read path; unmapped addresses read zero
    // Read data are registered, so a write in the read cycle is not seen
    // reg_rdata holds between reads; only reg_rvalid marks a fresh answer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_read) begin
                unique case (reg_addr)
                    ADDR_CHECK_EXC: reg_rdata <= {result_ready_flag, cfg2};
                    ADDR_ROUTE_OUT: reg_rdata <= cfg3;
                    ADDR_PIN_CTRL:  reg_rdata <= {1'b0, cfg4_ctrl[6:3], pin_level};
                    default:        reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ==========================================================================
    // Reserved-code detection on the stored fields
    // Codes stay as written so a read shows what the host sent;
    // the analog side learns of them through route_code_invalid instead
    assign route1_bad = (cfg3[POS_ROUTE1_LO +: 3] == ROUTE_RESERVED);
    assign route2_bad = (cfg3[POS_ROUTE2_LO +: 3] > ROUTE2_LAST);
    assign check_bad  = (cfg2[POS_CHECK_LO +: 2] == CHECK_RESERVED);

    // ==========================================================================
    // Field outputs, registered
    // Registering every field keeps all outputs straight from flip-flops,
    // at the cost of one edge of latency after each write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conversion_counter_enable <= 1'b0;
            integrity_check           <= CHECK_NONE;
            burnout_source_enable     <= 1'b0;
            excitation_current_level  <= 3'h0;
            first_source_route        <= 3'h0;
            second_source_route       <= 3'h0;
            auto_output_mode          <= 1'b0;
            route_code_invalid        <= 1'b0;
        end else begin
            conversion_counter_enable <= cfg2[POS_CNT_EN];
            integrity_check           <= acr_check_type'(cfg2[POS_CHECK_LO +: 2]);
            burnout_source_enable     <= cfg2[POS_BURNOUT];
            excitation_current_level  <= cfg2[POS_LEVEL_LO +: 3];
            first_source_route        <= cfg3[POS_ROUTE1_LO +: 3];
            second_source_route       <= cfg3[POS_ROUTE2_LO +: 3];
            auto_output_mode          <= cfg3[POS_AUTO];
            // Reserved route or check codes are reported, not acted upon
            route_code_invalid <= route1_bad || route2_bad || check_bad;
        end
    end

    // ==========================================================================
    // Decode of rate and magnitude
    // Rate and mode live in registers outside this bank, so they enter
    // as ports; the magnitude is taken from the stored field, which
    // keeps the decoded current in step with the level output
    acr_decode u_decode (
        .clk_sys                  (clk_sys),
        .reset                    (reset),
        .double_speed             (double_speed),
        .sample_rate_code         (sample_rate_code),
        .excitation_current_level (cfg2[POS_LEVEL_LO +: 3]),
        .sample_rate_sps          (sample_rate_sps),
        .rate_code_invalid        (rate_code_invalid),
        .excitation_ua            (excitation_ua),
        .modulator_khz            (modulator_khz)
    );

endmodule : acr_bank

// ---- acr_pin_model.sv ----
// Pin-side partner: resolves each general pin from device drive or outside level
module acr_pin_model (
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe,
    input  wire logic [2:0] ext_level,
    output logic      [2:0] pin_in
);
    // ==========================================================================
    // Pin resolution
    // The device wins a pin only while it drives it; otherwise the board level shows
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
        end
    end
endmodule : acr_pin_model

// ---- acr_bank_checker.sv ----
// Port-level assertions for the configuration register bank
module acr_bank_checker (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        double_speed,
    input wire logic [2:0]  sample_rate_code,
    input wire logic        result_done,
    input wire logic        result_read,
    input wire logic        result_ready_flag,
    input wire logic        rate_code_invalid,
    input wire logic [15:0] sample_rate_sps,
    input wire logic [15:0] modulator_khz
);
    // ==========================================================================
    // One clock domain, reset disables every check
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // ==========================================================================
    // Read answers
    a_read_answer: assert property (reg_read |=> reg_rvalid) else $error("read not answered");
    a_no_stray_valid: assert property (!reg_read |=> !reg_rvalid) else $error("stray read valid");
    a_unmapped_zero: assert property (reg_read && (reg_addr < 8'h02 || reg_addr > 8'h04)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_route_rsvd_zero: assert property (reg_read && reg_addr == 8'h03 |=> !reg_rdata[1])
        else $error("reserved route bit read high");
    a_pin_rsvd_zero: assert property (reg_read && reg_addr == 8'h04 |=> !reg_rdata[7])
        else $error("reserved pin bit read high");

    // ==========================================================================
    // Ready flag events
    a_flag_set_done: assert property (result_done |=> result_ready_flag) else $error("flag not set");
    a_flag_clear_read: assert property (result_read && !result_done |=> !result_ready_flag)
        else $error("flag not cleared");
    a_flag_holds_idle: assert property (!result_done && !result_read |=> $stable(result_ready_flag))
        else $error("flag moved without event");

    // ==========================================================================
    // Decode; three steady cycles cover the registered decode latency
    a_rate_rsvd_flag: assert property ((sample_rate_code == 3'h7) [*3]
        |-> rate_code_invalid && sample_rate_sps == 16'h0000) else $error("reserved rate not flagged");
    a_double_slowest: assert property ((double_speed && sample_rate_code == 3'h0) [*3]
        |-> sample_rate_sps == 16'h0028) else $error("double rate wrong");
    a_mode_clock_khz: assert property (double_speed [*3] |-> modulator_khz == 16'h0200)
        else $error("double modulator clock wrong");

    // ==========================================================================
    // Main scenarios reached
    c_flag_set: cover property (result_done ##1 result_ready_flag);
    c_unmapped: cover property (reg_read && reg_addr == 8'h05);
    c_double: cover property (double_speed && rate_code_invalid);
endmodule : acr_bank_checker

// ---- tb.sv ----
// Self-checking testbench of the configuration register bank
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acr_pkg::*;
    logic          clk_sys, reset, reg_write, reg_read, reg_rvalid, double_speed, result_done, result_read;
    logic [7:0]    reg_addr, reg_wdata, reg_rdata;
    logic [2:0]    sample_rate_code, pin_in, pin_out, pin_oe, ext_level, lvl, rt2;
    logic          result_ready_flag, conversion_counter_enable, burnout_source_enable;
    logic          auto_output_mode, route_code_invalid, rate_code_invalid;
    acr_check_type integrity_check;
    logic [2:0]    excitation_current_level, first_source_route, second_source_route;
    logic [15:0]   sample_rate_sps, excitation_ua, modulator_khz;
    int            mismatches, check_count;
    // Expected normal-mode rates and magnitudes, kept apart from the design's tables
    logic [15:0]   tb_sps [0:7] = '{16'h0014, 16'h002d, 16'h005a, 16'h00af, 16'h014a, 16'h0258, 16'h03e8, 16'h0};
    logic [15:0]   tb_ua [0:7] = '{16'h0, 16'h000a, 16'h0032, 16'h0064, 16'h00fa, 16'h01f4, 16'h03e8, 16'h05dc};

    acr_bank acr_bank_i (.clk_sys, .reset, .reg_addr, .reg_write, .reg_wdata, .reg_read, .reg_rdata,
        .reg_rvalid, .double_speed, .sample_rate_code, .result_done, .result_read, .pin_in, .pin_out,
        .pin_oe, .result_ready_flag, .conversion_counter_enable, .integrity_check, .burnout_source_enable,
        .excitation_current_level, .first_source_route, .second_source_route, .auto_output_mode,
        .route_code_invalid, .sample_rate_sps, .rate_code_invalid, .excitation_ua, .modulator_khz);
    acr_pin_model acr_pin_model_i (.pin_out, .pin_oe, .ext_level, .pin_in);

    // ==========================================================================
    // Clock, 10 ns period
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ==========================================================================
    // Access and check tasks
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Field outputs trail the store by one edge; three edges leave margin
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        settle();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        // Bounded wait for the one-cycle answer
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 4) begin
            mismatches++;
            tally_and_finish();
        end else begin
            chk("reg_rdata", {8'h0, reg_rdata}, {8'h0, exp});
        end
    endtask : rd
    // Pulse the result event or the data-read event for one cycle
    task automatic event_pulse(input logic set);
        @(posedge clk_sys);
        result_done <= set;
        result_read <= ~set;
        @(posedge clk_sys);
        result_done <= 1'b0;
        result_read <= 1'b0;
        settle();
    endtask : event_pulse
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================================
    // Main sequence
    initial begin
        {mismatches, check_count, reg_write, reg_read, reg_addr, reg_wdata, double_speed} = '0;
        {sample_rate_code, result_done, result_read, ext_level} = '0;
        reset = 1'b1;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        for (int a = 1; a < 6; a++) rd(8'(a), 8'h00);
        chk("modulator_khz", modulator_khz, 16'h0100);
        $display("test reset done");
        // Every rate code in both modes, reserved code included on purpose
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 8; c++) begin
                @(posedge clk_sys);
                double_speed <= m[0];
                sample_rate_code <= c[2:0];
                settle();
                chk("sps", sample_rate_sps, tb_sps[c] << m);
                chk("rate_bad", {15'h0, rate_code_invalid}, {15'h0, c == 7});
                chk("khz", modulator_khz, 16'h0100 << m);
            end
        end
        $display("test rate done");
        // Register 2: every magnitude and check code; the flag bit write is ignored
        for (int c = 0; c < 8; c++) begin
            lvl = c[2:0];
            wr(8'h02, {2'h2 | lvl[0], lvl[1:0], lvl[0], lvl});
            rd(8'h02, {1'b0, lvl[0], lvl[1:0], lvl[0], lvl});
            chk("cfg2", {8'h0, conversion_counter_enable, burnout_source_enable, integrity_check,
                route_code_invalid, excitation_current_level}, {8'h0, {2{lvl[0]}}, lvl[1:0], &lvl[1:0], lvl});
            chk("ua", excitation_ua, tb_ua[c]);
        end
        wr(8'h02, 8'h00);
        $display("test cfg2 done");
        // Register 3: routes, output mode, reserved bit refused
        for (int c = 0; c < 8; c++) begin
            lvl = c[2:0];
            rt2 = (c == 5 || c == 6) ? 3'h0 : lvl;
            wr(8'h03, {lvl, rt2, 1'b1, lvl[0]});
            rd(8'h03, {lvl, rt2, 1'b0, lvl[0]});
            chk("cfg3", {7'h0, first_source_route, second_source_route, auto_output_mode, route_code_invalid},
                {7'h0, lvl, rt2, lvl[0], c == 7});
        end
        wr(8'h03, 8'h00);
        $display("test cfg3 done");
        // Ready flag: set by a result, kept through a write, cleared by a data read
        event_pulse(1'b1);
        chk("flag_set", {15'h0, result_ready_flag}, 16'h0001);
        wr(8'h02, 8'h00);
        rd(8'h02, 8'h80);
        event_pulse(1'b0);
        chk("flag_clr", {15'h0, result_ready_flag}, 16'h0000);
        rd(8'h02, 8'h00);
        $display("test flag done");
        // Pins: inputs sampled, outputs driven, pin 2 follows level or ready
        @(posedge clk_sys);
        ext_level <= 3'h5;
        wr(8'h04, 8'h80);
        rd(8'h04, 8'h05);
        chk("pins_in", {13'h0, pin_oe}, 16'h0);
        wr(8'h04, 8'h7b);
        chk("pins_rdy0", {10'h0, pin_oe, pin_out}, 16'h003b);
        event_pulse(1'b1);
        chk("pins_rdy1", {13'h0, pin_out}, 16'h0007);
        wr(8'h04, 8'h74);
        chk("pins_lvl", {13'h0, pin_out}, 16'h0004);
        // Pin 1 is an input with its level bit set: readback shows the pin, not the bit
        wr(8'h04, 8'h52);
        chk("pins_mix", {10'h0, pin_oe, pin_out & pin_oe}, 16'h0028);
        rd(8'h04, 8'h50);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        rd(8'h04, 8'h50);
        $display("test pins done");
        // Mid-run reset: flag, fields and pin drive return to zero
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h05);
        chk("pins_rst", {10'h0, pin_oe, pin_out}, 16'h0000);
        chk("khz_rst", modulator_khz, 16'h0200);
        $display("test reset rerun done");
        tally_and_finish();
    end
endmodule : tb

bind acr_bank acr_bank_checker acr_bank_checker_i (.clk_sys, .reset, .reg_addr, .reg_read, .reg_rdata,
    .reg_rvalid, .double_speed, .sample_rate_code, .result_done, .result_read, .result_ready_flag,
    .rate_code_invalid, .sample_rate_sps, .modulator_khz);
